// ---- rtl/eocd_decoder.sv ----
/*
  four-byte extended opcode decoder with execution-time calculator.
  assumes opcode and cycle counts come from same-clock core logic, held while
  start is high for one cycle; busy covers the six-cycle accumulation plus the result cycle, seven cycles in all.
*/
// Function
// RULE1 - execution states are the sum of each category count times its state cost
// RULE2 - instructions carry six separate counts: fetch, branch, stack, byte, word, internal
// RULE3 - on-chip memory costs 2 states per cycle, internal operations 1 state
// RULE4 - supporting modules cost 6 or 3 states on 8-bit, 3 on 16-bit
// RULE5 - external 8-bit costs 4/2 in two-state, 6+2m/3+m in three-state
// RULE6 - external 16-bit costs 2 in two-state, 3+m in three-state
// RULE7 - stack cycles are priced by where the stack resides
// RULE8 - prefixes 7C/7D use a register field for the operand address
// RULE9 - prefixes 7E/7F use an 8-bit absolute address field
// RULE10 - shared positions pick inverted form when fourth byte bit 7 is set
// RULE11 - 01C05/01D05 signed mul/div, 01F06 long logic, 01406 control load/store
`timescale 1ns/1ps
`include "eocd_cfg.svh"
module eocd_decoder
  import eocd_pkg::*;
#(
  parameter int CNT_W  = 4,
  parameter int WAIT_W = 4,
  parameter int SUM_W  = 12
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // request
  input  wire logic              start,
  input  wire logic [31:0]       opcode,
  input  wire logic [CNT_W-1:0]  cnt_fetch,
  input  wire logic [CNT_W-1:0]  cnt_branch,
  input  wire logic [CNT_W-1:0]  cnt_stack,
  input  wire logic [CNT_W-1:0]  cnt_byte,
  input  wire logic [CNT_W-1:0]  cnt_word,
  input  wire logic [CNT_W-1:0]  cnt_intop,
  // access conditions
  input  wire eocd_tgt_e         code_tgt,
  input  wire eocd_tgt_e         data_tgt,
  input  wire eocd_tgt_e         stack_tgt,
  input  wire logic              three_state,
  input  wire logic [WAIT_W-1:0] waits,
  // decode results
  output logic                   busy,
  output logic                   done,
  output eocd_op_e               op,
  output logic                   op_valid,
  output logic                   use_reg,
  output logic [2:0]             addr_reg,
  output logic [7:0]             abs_addr,
  output logic [2:0]             bit_num,
  output logic [SUM_W-1:0]       exec_states
);
  eocd_fsm_e        fsm_q, fsm_d;
  logic [2:0]       cat_q, cat_d;
  logic [SUM_W-1:0] acc_q, acc_d;
  logic [CNT_W-1:0] cnt_q [6];
  logic [CNT_W-1:0] cnt_d [6];
  logic             done_q, done_d;
  eocd_op_e         op_q, op_d;
  logic             vld_q, vld_d;
  logic             ureg_q, ureg_d;
  logic [2:0]       areg_q, areg_d;
  logic [7:0]       abs_q, abs_d;
  logic [2:0]       bit_q, bit_d;
  logic [SUM_W-1:0] res_q, res_d;
  eocd_tgt_e        cur_tgt;
  logic [7:0]       cyc_states;
  logic [CNT_W-1:0] cur_cnt;
  logic [7:0]       b1, b2, b3, b4;
  logic             inv;
  eocd_op_e         dop;
  logic             dvld;

  initial begin
    if (CNT_W < 1 || CNT_W > 8) $error("eocd_decoder: CNT_W out of range");
    if (SUM_W < CNT_W + 8) $error("eocd_decoder: SUM_W too narrow");
  end

  // opcode decode, purely combinational from the held opcode
  always_comb begin
    b1   = opcode[31:24];
    b2   = opcode[23:16];
    b3   = opcode[15:8];
    b4   = opcode[7:0];
    inv  = b4[7]; // see RULE10
    dop  = EOCD_OP_NONE;
    dvld = 1'b0;
    // the prefix is five nibbles; the third byte's low nibble is the column
    if (b1 == `EOCD_PFX_01 && b2 == `EOCD_B2_MUL && b3[7:4] == `EOCD_CH_5) begin
      dvld = (b3[3:0] == 4'h0 || b3[3:0] == 4'h2); // see RULE11
      dop  = dvld ? EOCD_OP_SMUL : EOCD_OP_NONE;
    end else if (b1 == `EOCD_PFX_01 && b2 == `EOCD_B2_DIV && b3[7:4] == `EOCD_CH_5) begin
      dvld = (b3[3:0] == 4'h1 || b3[3:0] == 4'h3); // see RULE11
      dop  = dvld ? EOCD_OP_SDIV : EOCD_OP_NONE;
    end else if (b1 == `EOCD_PFX_01 && b2 == `EOCD_B2_LOG && b3[7:4] == `EOCD_CH_6) begin
      dvld = 1'b1;
      case (b3[3:0])
        4'h4:    dop = EOCD_OP_LOR; // see RULE11
        4'h5:    dop = EOCD_OP_LXOR;
        4'h6:    dop = EOCD_OP_LAND;
        default: dvld = 1'b0;
      endcase
    end else if (b1 == `EOCD_PFX_01 && b2 == `EOCD_B2_CTL && b3[7:4] == `EOCD_CH_6) begin
      // odd columns 9..f: fourth byte bit 7 picks store over load
      if (b3[3:0] == 4'h9 || b3[3:0] == 4'hb || b3[3:0] == 4'hd || b3[3:0] == 4'hf) begin
        dop  = inv ? EOCD_OP_STCR : EOCD_OP_LDCR; // see RULE10 RULE11
        dvld = 1'b1;
      end
    end else if ((b1 == `EOCD_PFX_RI_T || b1 == `EOCD_PFX_AB_T) &&
                 (b3[7:4] == `EOCD_CH_6 || b3[7:4] == `EOCD_CH_7)) begin
      dvld = 1'b1;
      case (b3[3:0])
        4'h3:    dop = EOCD_OP_BIT_TEST; // see RULE8
        4'h4:    dop = (b3[7:4] == `EOCD_CH_7) ? (inv ? EOCD_OP_BIT_INV_OR : EOCD_OP_BIT_OR)
                                               : EOCD_OP_NONE;
        4'h5:    dop = (b3[7:4] == `EOCD_CH_7) ? (inv ? EOCD_OP_BIT_INV_XOR : EOCD_OP_BIT_XOR)
                                               : EOCD_OP_NONE;
        4'h6:    dop = (b3[7:4] == `EOCD_CH_7) ? (inv ? EOCD_OP_BIT_INV_AND : EOCD_OP_BIT_AND)
                                               : EOCD_OP_NONE;
        default: dop = EOCD_OP_NONE;
      endcase
      if (dop == EOCD_OP_NONE) dvld = 1'b0;
    end else if ((b1 == `EOCD_PFX_RI_S || b1 == `EOCD_PFX_AB_S) &&
                 (b3[7:4] == `EOCD_CH_6 || b3[7:4] == `EOCD_CH_7)) begin
      dvld = 1'b1;
      case (b3[3:0])
        4'h0:    dop = EOCD_OP_BIT_SET; // see RULE8
        4'h1:    dop = EOCD_OP_BIT_INVERT;
        4'h2:    dop = EOCD_OP_BIT_CLEAR;
        4'h7:    dop = (b3[7:4] == `EOCD_CH_6) ? (inv ? EOCD_OP_BIT_INV_STORE : EOCD_OP_BIT_STORE)
                                               : EOCD_OP_NONE;
        default: dop = EOCD_OP_NONE;
      endcase
      if (dop == EOCD_OP_NONE) dvld = 1'b0;
    end
  end

  // category walk: one category per cycle keeps a single cost lookup
  always_comb begin
    cur_cnt = cnt_q[cat_q];
    case (cat_q)
      EOCD_CAT_STACK:                 cur_tgt = stack_tgt; // see RULE7
      EOCD_CAT_BYTE, EOCD_CAT_WORD:   cur_tgt = data_tgt;
      default:                        cur_tgt = code_tgt;
    endcase
  end

  eocd_state_cost #(
    .WAIT_W (WAIT_W)
  ) u_cost (
    .cat         (cat_q),
    .tgt         (cur_tgt),
    .three_state (three_state),
    .waits       (waits),
    .states      (cyc_states)
  );

  always_comb begin
    fsm_d  = fsm_q;
    cat_d  = cat_q;
    acc_d  = acc_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    op_d   = op_q;
    vld_d  = vld_q;
    ureg_d = ureg_q;
    areg_d = areg_q;
    abs_d  = abs_q;
    bit_d  = bit_q;
    res_d  = res_q;
    case (fsm_q)
      EOCD_ST_IDLE: begin
        if (start) begin
          cnt_d  = '{cnt_fetch, cnt_branch, cnt_stack, cnt_byte, cnt_word, cnt_intop}; // see RULE2
          cat_d  = EOCD_CAT_FETCH;
          acc_d  = '0;
          op_d   = dop;
          vld_d  = dvld;
          ureg_d = (b1 == `EOCD_PFX_RI_T || b1 == `EOCD_PFX_RI_S); // see RULE8
          areg_d = b2[6:4]; // see RULE8
          abs_d  = b2; // see RULE9
          bit_d  = b4[6:4];
          fsm_d  = EOCD_ST_ACC;
        end
      end
      EOCD_ST_ACC: begin
        acc_d = acc_q + SUM_W'(cur_cnt) * SUM_W'(cyc_states); // see RULE1
        if (cat_q == EOCD_CAT_INTOP) begin
          fsm_d = EOCD_ST_DONE;
        end else begin
          cat_d = cat_q + 3'h1;
        end
      end
      EOCD_ST_DONE: begin
        res_d  = acc_q;
        done_d = 1'b1;
        fsm_d  = EOCD_ST_IDLE;
      end
      default: fsm_d = EOCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fsm_q  <= EOCD_ST_IDLE;
      cat_q  <= EOCD_CAT_FETCH;
      acc_q  <= '0;
      cnt_q  <= '{default: '0};
      done_q <= 1'b0;
      op_q   <= EOCD_OP_NONE;
      vld_q  <= 1'b0;
      ureg_q <= 1'b0;
      areg_q <= 3'h0;
      abs_q  <= 8'h00;
      bit_q  <= 3'h0;
      res_q  <= '0;
    end else begin
      fsm_q  <= fsm_d;
      cat_q  <= cat_d;
      acc_q  <= acc_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      op_q   <= op_d;
      vld_q  <= vld_d;
      ureg_q <= ureg_d;
      areg_q <= areg_d;
      abs_q  <= abs_d;
      bit_q  <= bit_d;
      res_q  <= res_d;
    end
  end

  logic busy_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) busy_q <= 1'b0;
    else        busy_q <= (fsm_d != EOCD_ST_IDLE);
  end

  assign busy        = busy_q;
  assign done        = done_q;
  assign op          = op_q;
  assign op_valid    = vld_q;
  assign use_reg     = ureg_q;
  assign addr_reg    = areg_q;
  assign abs_addr    = abs_q;
  assign bit_num     = bit_q;
  assign exec_states = res_q;

  // checks
  chk_done_after_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && fsm_q == EOCD_ST_IDLE) |-> ##8 done) // see RULE1
    else $error("done did not follow start by eight cycles");
  chk_intop_one_state: assert property (@(posedge mclk) disable iff (!rst_b)
    (cat_q == EOCD_CAT_INTOP) |-> cyc_states == `EOCD_ST_INTOP) // see RULE3
    else $error("internal cycle not one state");
  chk_onchip_two: assert property (@(posedge mclk) disable iff (!rst_b)
    (fsm_q == EOCD_ST_ACC && cat_q != EOCD_CAT_INTOP && cur_tgt == EOCD_TGT_ONCHIP)
    |-> cyc_states == `EOCD_ST_ONCHIP) // see RULE3
    else $error("on-chip cycle not two states");
  chk_sup16_three: assert property (@(posedge mclk) disable iff (!rst_b)
    (cat_q != EOCD_CAT_INTOP && cur_tgt == EOCD_TGT_SUP16) |-> cyc_states == 8'h03) // see RULE4
    else $error("16-bit module cycle not three states");
  chk_ext16_cost: assert property (@(posedge mclk) disable iff (!rst_b)
    (cat_q != EOCD_CAT_INTOP && cur_tgt == EOCD_TGT_EXT16 && three_state)
    |-> cyc_states == 8'(8'h03 + 8'(waits))) // see RULE6
    else $error("external 16-bit three-state cost wrong");
  chk_ext8_byte: assert property (@(posedge mclk) disable iff (!rst_b)
    (cat_q == EOCD_CAT_BYTE && cur_tgt == EOCD_TGT_EXT8 && !three_state)
    |-> cyc_states == 8'h02) // see RULE5
    else $error("external 8-bit byte cost wrong");
  chk_stack_target: assert property (@(posedge mclk) disable iff (!rst_b)
    (cat_q == EOCD_CAT_STACK && stack_tgt == EOCD_TGT_EXT8 && !three_state)
    |-> cyc_states == 8'h04) // see RULE7
    else $error("stack cycle priced on wrong target");
  chk_reg_form: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && fsm_q == EOCD_ST_IDLE && opcode[31:24] == 8'h7c) |=> use_reg) // see RULE8
    else $error("register-indirect form not flagged");
  chk_abs_form: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && fsm_q == EOCD_ST_IDLE && opcode[31:24] == 8'h7f)
    |=> !use_reg && abs_addr == $past(opcode[23:16])) // see RULE9
    else $error("absolute form address wrong");
  chk_inverted_pick: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && fsm_q == EOCD_ST_IDLE && opcode[31:24] == 8'h7c && opcode[15:8] == 8'h74
     && opcode[7]) |=> op == EOCD_OP_BIT_INV_OR) // see RULE10
    else $error("inverted form not selected");
  chk_smul_map: assert property (@(posedge mclk) disable iff (!rst_b)
    (start && fsm_q == EOCD_ST_IDLE && opcode[31:12] == 20'h01c05 && opcode[11:8] == 4'h0)
    |=> op == EOCD_OP_SMUL && op_valid) // see RULE11
    else $error("signed multiply not decoded");
  cov_bit_op:  cover property (@(posedge mclk) done && op_valid && use_reg);
  cov_abs_op:  cover property (@(posedge mclk) done && op_valid && !use_reg);
  cov_bad_op:  cover property (@(posedge mclk) done && !op_valid);
endmodule

// ---- rtl/eocd_cfg.svh ----
/*
  constants for the extended opcode decoder and the state cost calculator.
  assumes inclusion by the package and by the design modules.
*/
`ifndef EOCD_CFG_SVH
`define EOCD_CFG_SVH

// opcode prefixes
`define EOCD_PFX_01    8'h01
`define EOCD_PFX_RI_T  8'h7c
`define EOCD_PFX_RI_S  8'h7d
`define EOCD_PFX_AB_T  8'h7e
`define EOCD_PFX_AB_S  8'h7f
`define EOCD_B2_MUL    8'hc0
`define EOCD_B2_DIV    8'hd0
`define EOCD_B2_LOG    8'hf0
`define EOCD_B2_CTL    8'h40
`define EOCD_CH_5      4'h5
`define EOCD_CH_6      4'h6
`define EOCD_CH_7      4'h7

// states per cycle
`define EOCD_ST_ONCHIP   8'h02
`define EOCD_ST_INTOP    8'h01
`define EOCD_ST_SUP8_W   8'h06
`define EOCD_ST_SUP8_B   8'h03
`define EOCD_ST_SUP16    8'h03
`define EOCD_ST_EX8_2W   8'h04
`define EOCD_ST_EX8_2B   8'h02
`define EOCD_ST_EX8_3W   8'h06
`define EOCD_ST_EX8_3B   8'h03
`define EOCD_ST_EX16_2   8'h02
`define EOCD_ST_EX16_3   8'h03

`endif

// ---- rtl/eocd_pkg.sv ----
/*
  types for the extended opcode decoder.
  assumes eocd_cfg.svh is on the include path.
*/
`include "eocd_cfg.svh"
package eocd_pkg;
  typedef enum logic [4:0] {
    EOCD_TGT_ONCHIP = 5'h01,
    EOCD_TGT_SUP8   = 5'h02,
    EOCD_TGT_SUP16  = 5'h04,
    EOCD_TGT_EXT8   = 5'h08,
    EOCD_TGT_EXT16  = 5'h10
  } eocd_tgt_e;

  typedef enum logic [4:0] {
    EOCD_OP_NONE = 5'h00, EOCD_OP_BIT_TEST, EOCD_OP_BIT_OR, EOCD_OP_BIT_INV_OR,
    EOCD_OP_BIT_XOR, EOCD_OP_BIT_INV_XOR, EOCD_OP_BIT_AND, EOCD_OP_BIT_INV_AND,
    EOCD_OP_BIT_SET, EOCD_OP_BIT_INVERT, EOCD_OP_BIT_CLEAR, EOCD_OP_BIT_STORE,
    EOCD_OP_BIT_INV_STORE, EOCD_OP_SMUL, EOCD_OP_SDIV, EOCD_OP_LOR, EOCD_OP_LXOR,
    EOCD_OP_LAND, EOCD_OP_LDCR, EOCD_OP_STCR
  } eocd_op_e;

  typedef enum logic [2:0] {
    EOCD_CAT_FETCH = 3'h0, EOCD_CAT_BRANCH, EOCD_CAT_STACK,
    EOCD_CAT_BYTE, EOCD_CAT_WORD, EOCD_CAT_INTOP
  } eocd_cat_e;

  typedef enum logic [2:0] {
    EOCD_ST_IDLE = 3'b001,
    EOCD_ST_ACC  = 3'b010,
    EOCD_ST_DONE = 3'b100
  } eocd_fsm_e;
endpackage

// ---- rtl/eocd_state_cost.sv ----
/*
  per-cycle state count lookup for one cycle category.
  assumes target and mode inputs are stable for the cycle they price.
*/
`timescale 1ns/1ps
`include "eocd_cfg.svh"
module eocd_state_cost
  import eocd_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  // selection
  input  wire logic [2:0]        cat,
  input  wire eocd_tgt_e         tgt,
  input  wire logic              three_state,
  input  wire logic [WAIT_W-1:0] waits,
  // result
  output logic [7:0]             states
);
  logic [7:0] m8;
  logic       bytec;
  logic       wordc;

  initial begin
    if (WAIT_W < 1 || WAIT_W > 6) $error("eocd_state_cost: WAIT_W out of range");
  end

  always_comb begin
    m8    = 8'(waits);
    bytec = (cat == EOCD_CAT_BYTE);
    wordc = !bytec && (cat != EOCD_CAT_INTOP);
    states = `EOCD_ST_INTOP;
    if (cat == EOCD_CAT_INTOP) begin
      states = `EOCD_ST_INTOP; // see RULE3
    end else if (tgt == EOCD_TGT_ONCHIP) begin
      states = `EOCD_ST_ONCHIP; // see RULE3
    end else if (tgt == EOCD_TGT_SUP8) begin
      states = bytec ? `EOCD_ST_SUP8_B : `EOCD_ST_SUP8_W; // see RULE4
    end else if (tgt == EOCD_TGT_SUP16) begin
      states = `EOCD_ST_SUP16; // see RULE4
    end else if (tgt == EOCD_TGT_EXT8) begin
      if (three_state) begin
        states = wordc ? 8'(`EOCD_ST_EX8_3W + (m8 << 1)) : 8'(`EOCD_ST_EX8_3B + m8); // see RULE5
      end else begin
        states = wordc ? `EOCD_ST_EX8_2W : `EOCD_ST_EX8_2B; // see RULE5
      end
    end else begin
      states = three_state ? 8'(`EOCD_ST_EX16_3 + m8) : `EOCD_ST_EX16_2; // see RULE6
    end
  end
endmodule

// ---- verification/eocd_partner.sv ----
/*
  memory-system model: supplies the access conditions under which an
  instruction is priced. assumes the decoder's busy output is connected.
*/
`timescale 1ns/1ps
module eocd_partner
  import eocd_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // core side
  input  wire logic       busy,
  input  wire logic [2:0] sel,
  // access conditions
  output eocd_tgt_e       code_tgt,
  output eocd_tgt_e       data_tgt,
  output eocd_tgt_e       stack_tgt,
  output logic            three_state,
  output logic [3:0]      waits
);
  logic [19:0] cfg_q;

  // conditions only move between instructions, never while a sum runs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= {EOCD_TGT_ONCHIP, EOCD_TGT_ONCHIP, EOCD_TGT_ONCHIP, 5'h00};
    end else if (!busy) begin
      case (sel)
        3'h1: cfg_q <= {EOCD_TGT_SUP8, EOCD_TGT_SUP8, EOCD_TGT_EXT16, 5'h13};
        3'h2: cfg_q <= {EOCD_TGT_SUP16, EOCD_TGT_EXT8, EOCD_TGT_EXT8, 5'h00};
        3'h3: cfg_q <= {EOCD_TGT_EXT8, EOCD_TGT_EXT8, EOCD_TGT_EXT8, 5'h12};
        3'h4: cfg_q <= {EOCD_TGT_EXT16, EOCD_TGT_EXT16, EOCD_TGT_SUP8, 5'h12};
        3'h5: cfg_q <= {EOCD_TGT_EXT16, EOCD_TGT_SUP16, EOCD_TGT_EXT16, 5'h00};
        3'h6: cfg_q <= {EOCD_TGT_EXT16, EOCD_TGT_SUP8, EOCD_TGT_EXT16, 5'h11};
        default: cfg_q <= {EOCD_TGT_ONCHIP, EOCD_TGT_ONCHIP, EOCD_TGT_ONCHIP, 5'h00};
      endcase
    end
  end

  assign code_tgt    = eocd_tgt_e'(cfg_q[19:15]);
  assign data_tgt    = eocd_tgt_e'(cfg_q[14:10]);
  assign stack_tgt   = eocd_tgt_e'(cfg_q[9:5]);
  assign three_state = cfg_q[4];
  assign waits       = cfg_q[3:0];
endmodule

// ---- verification/tb.sv ----
/*
  self-checking bench for the extended opcode decoder and state costing.
  assumes eocd_pkg and eocd_partner are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import eocd_pkg::*;
  logic        mclk, rst_b, start, three_state, busy, done, op_valid, use_reg;
  logic [31:0] opcode;
  logic [3:0]  c_i, c_j, c_k, c_l, c_m, c_n, waits;
  logic [2:0]  sel, addr_reg, bit_num;
  logic [7:0]  abs_addr;
  logic [11:0] exec_states;
  eocd_tgt_e   code_tgt, data_tgt, stack_tgt;
  eocd_op_e    op;
  int          errors, checks_done;
  logic [31:0] dop [19];
  logic [16:0] dex [19];

  eocd_partner mem_u (.mclk(mclk), .rst_b(rst_b), .busy(busy), .sel(sel),
    .code_tgt(code_tgt), .data_tgt(data_tgt), .stack_tgt(stack_tgt),
    .three_state(three_state), .waits(waits));

  eocd_decoder dut_u (.mclk(mclk), .rst_b(rst_b), .start(start), .opcode(opcode),
    .cnt_fetch(c_i), .cnt_branch(c_j), .cnt_stack(c_k), .cnt_byte(c_l),
    .cnt_word(c_m), .cnt_intop(c_n), .code_tgt(code_tgt), .data_tgt(data_tgt),
    .stack_tgt(stack_tgt), .three_state(three_state), .waits(waits), .busy(busy),
    .done(done), .op(op), .op_valid(op_valid), .use_reg(use_reg),
    .addr_reg(addr_reg), .abs_addr(abs_addr), .bit_num(bit_num),
    .exec_states(exec_states));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // opcode is scrambled after the taking edge: it is only held for one cycle
  task automatic drv(input logic [31:0] opc);
    start = 1'b1;
    opcode = opc;
    @(posedge mclk);
    #1;
    start = 1'b0;
    opcode = ~opc;
  endtask

  task automatic wdone(input logic [11:0] exp);
    repeat (7) begin
      check(busy, 1'b1);
      @(posedge mclk);
      #1;
    end
    check(done, 1'b1);
    check(exec_states, exp);
    check(busy, 1'b0);
  endtask

  task automatic counts(input logic [23:0] v);
    {c_i, c_j, c_k, c_l, c_m, c_n} = v;
  endtask

  function automatic int sc(int cat, eocd_tgt_e t, logic ts, int m);
    logic bl;
    bl = (cat == 3);
    if (cat == 5) return 1;
    case (t)
      EOCD_TGT_ONCHIP: return 2;
      EOCD_TGT_SUP8:   return bl ? 3 : 6;
      EOCD_TGT_SUP16:  return 3;
      EOCD_TGT_EXT8:   return ts ? (bl ? 3 + m : 6 + 2 * m) : (bl ? 2 : 4);
      default:         return ts ? 3 + m : 2;
    endcase
  endfunction

  task automatic t_reset();
    check(busy, 1'b0);
    check(done, 1'b0);
    check(op, EOCD_OP_NONE);
    check(exec_states, 12'h000);
  endtask

  // counts are cleared after the take to show they are sampled at start
  task automatic t_cost();
    int e;
    for (int s = 0; s < 7; s++) begin
      sel = 3'(s);
      repeat (2) @(posedge mclk);
      #1;
      counts(24'h312457);
      e = 3 * sc(0, code_tgt, three_state, waits) + sc(1, code_tgt, three_state, waits);
      e += 2 * sc(2, stack_tgt, three_state, waits) + 4 * sc(3, data_tgt, three_state, waits);
      e += 5 * sc(4, data_tgt, three_state, waits) + 7;
      drv(32'h7c306320);
      counts(24'h000000);
      wdone(12'(e));
    end
    counts(24'h200200);
    drv(32'h7fc76000);
    counts(24'h000000);
    wdone(12'd14);
  endtask

  task automatic t_decode();
    for (int i = 0; i < 19; i++) begin
      drv(dop[i]);
      check(op, dex[i][16:12]);
      check(op_valid, dex[i][16:12] != 5'h00);
      if (i < 11) check({use_reg, use_reg ? {5'h0, addr_reg} : abs_addr, bit_num},
                        dex[i][11:0]);
      wdone(12'h000);
    end
  endtask

  // a second start inside the busy span must leave the first one alone
  task automatic t_refuse();
    drv(32'h7c306320);
    repeat (2) @(posedge mclk);
    #1;
    drv(32'h7f816710);
    check(op, EOCD_OP_BIT_TEST);
    repeat (4) @(posedge mclk);
    #1;
    check(done, 1'b1);
    check(op, EOCD_OP_BIT_TEST);
    @(posedge mclk);
    #1;
    check(done, 1'b0);
    check(busy, 1'b0);
  endtask

  task automatic t_b2b();
    drv(32'h7e5a6340);
    repeat (7) @(posedge mclk);
    #1;
    check(done, 1'b1);
    counts(24'h100002);
    drv(32'h7d406000);
    counts(24'h000000);
    check(op, EOCD_OP_BIT_SET);
    wdone(12'd6);
  endtask

  initial begin
    #(25 * 4000);
    errors++;
    final_report();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    rst_b = 1'b0;
    start = 1'b0;
    opcode = 32'h0;
    sel = 3'h0;
    counts(24'h000000);
    dop = '{32'h7c306320, 32'h7c1074d0, 32'h7c207530, 32'h7c5076f0, 32'h7d406000,
            32'h7d707110, 32'h7d0067c0, 32'h7e5a6340, 32'h7fc36260, 32'h7f816710,
            32'h7e127430, 32'h01c05000, 32'h01d05300, 32'h01f06400, 32'h01f06500,
            32'h01f06600, 32'h01406900, 32'h01406b80, 32'h7c006800};
    dex = '{{EOCD_OP_BIT_TEST, 12'h81a}, {EOCD_OP_BIT_INV_OR, 12'h80d},
            {EOCD_OP_BIT_XOR, 12'h813}, {EOCD_OP_BIT_INV_AND, 12'h82f},
            {EOCD_OP_BIT_SET, 12'h820}, {EOCD_OP_BIT_INVERT, 12'h839},
            {EOCD_OP_BIT_INV_STORE, 12'h804}, {EOCD_OP_BIT_TEST, 12'h2d4},
            {EOCD_OP_BIT_CLEAR, 12'h61e}, {EOCD_OP_BIT_STORE, 12'h409},
            {EOCD_OP_BIT_OR, 12'h093}, {EOCD_OP_SMUL, 12'h0},
            {EOCD_OP_SDIV, 12'h0}, {EOCD_OP_LOR, 12'h0}, {EOCD_OP_LXOR, 12'h0},
            {EOCD_OP_LAND, 12'h0}, {EOCD_OP_LDCR, 12'h0}, {EOCD_OP_STCR, 12'h0},
            {EOCD_OP_NONE, 12'h0}};
    repeat (20) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_cost();
    t_decode();
    t_refuse();
    t_b2b();
    final_report();
  end
endmodule
